//--- dv/modem_sync_signal_strength_and_channel_config_sva.sv
// Purpose: Port assertions for the modem sync / signal-strength block
// Assumes: Bound to every instance of modem_sync_signal_strength_and_channel_config
// Notes:   Sees top-level ports only, so threshold values are not visible here
`timescale 1ns/100ps
`default_nettype none
module modem_sync_signal_strength_and_channel_config_sva (
   // System
   input wire logic       CLK,
   input wire logic       RESETN,
   // Stimulus seen
   input wire logic       RX_ENABLE,
   input wire logic       SYMBOL_STROBE,
   input wire logic       TX_SYNC_START,
   // Outputs watched
   input wire logic       SFD_SEARCH_EN,
   input wire logic       FREQ_FILTER_HOLD,
   input wire logic       SIGNAL_STRENGTH_VALID,
   input wire logic [3:0] TX_SYMBOL,
   input wire logic       TX_SYNC_ACTIVE,
   input wire logic       RX_SYNC_FOUND
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // ==========================================================
   // Assertions
   a_search_needs_rx: assert property (SFD_SEARCH_EN |-> $past(RX_ENABLE))
      else $error("search enabled with receiver off");
   a_hold_needs_rx: assert property (FREQ_FILTER_HOLD |-> $past(RX_ENABLE))
      else $error("filter held with receiver off");
   a_valid_drops: assert property (!RX_ENABLE |=> !SIGNAL_STRENGTH_VALID)
      else $error("strength valid with receiver off");
   a_valid_on_strobe: assert property ($rose(SIGNAL_STRENGTH_VALID) |-> $past(SYMBOL_STROBE) && $past(RX_ENABLE))
      else $error("strength valid rose without a symbol");
   a_tx_no_f: assert property (TX_SYNC_ACTIVE |-> TX_SYMBOL != 4'hf)
      else $error("pattern nibble f sent as is");
   a_tx_idle_zero: assert property (!TX_SYNC_ACTIVE |-> TX_SYMBOL == 4'h0)
      else $error("symbol not zero while idle");
   a_tx_start: assert property (TX_SYNC_START && !TX_SYNC_ACTIVE |=> TX_SYNC_ACTIVE)
      else $error("sync send did not start");
   a_found_pulse: assert property (RX_SYNC_FOUND |-> $past(SYMBOL_STROBE, 2) ##1 !RX_SYNC_FOUND)
      else $error("sync found not a timed pulse");
endmodule

bind modem_sync_signal_strength_and_channel_config modem_sync_signal_strength_and_channel_config_sva modem_sync_signal_strength_and_channel_config_sva_inst (
   .CLK(CLK), .RESETN(RESETN), .RX_ENABLE(RX_ENABLE), .SYMBOL_STROBE(SYMBOL_STROBE),
   .TX_SYNC_START(TX_SYNC_START), .SFD_SEARCH_EN(SFD_SEARCH_EN), .FREQ_FILTER_HOLD(FREQ_FILTER_HOLD),
   .SIGNAL_STRENGTH_VALID(SIGNAL_STRENGTH_VALID), .TX_SYMBOL(TX_SYMBOL),
   .TX_SYNC_ACTIVE(TX_SYNC_ACTIVE), .RX_SYNC_FOUND(RX_SYNC_FOUND));
`default_nettype wire

//--- dv/test_modem_sync_signal_strength_and_channel_config.sv
// Purpose: Self-checking bench for the modem sync / signal-strength block
// Assumes: Frame is address byte then 16 data bits, MSB first
// Notes:   SCLK phases of 8 CLK keep SO sampling clear of its sync delay
`timescale 1ns/100ps
`include "modem_sync_signal_strength_and_channel_defines.vh"
`default_nettype none
module test_modem_sync_signal_strength_and_channel_config;
   logic            CLK, RESETN, SCLK, CSN, SI, RX_ENABLE, SYMBOL_STROBE, PREAMBLE_MATCH, TX_SYNC_START;
   logic [3:0]      RX_SYMBOL;
   logic [7:0]      SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE;
   logic [4:0]      CORR_LEVEL;
   logic [2:0]      CLEAR_CHANNEL_HYSTERESIS;
   wire logic       SO, SO_OE, SFD_SEARCH_EN, FREQ_FILTER_HOLD, PHASE_INVERT, CHANNEL_FREE_FLAG;
   wire logic       SIGNAL_STRENGTH_VALID, TX_SYNC_ACTIVE, RX_SYNC_FOUND;
   wire logic [1:0] TX_SOURCE, RX_DEST;
   wire logic [3:0] TX_SYMBOL;
   int              fail_count, checks_done, found_seen;
   logic [15:0]     sdata;
   logic            oe_seen;
   logic [3:0]      txe [4] = '{4'h0, 4'h2, 4'h0, 4'h1};
   logic [3:0]      rxs [3][5] = '{'{4'h0, 4'h1, 4'h3, 4'h9, 4'h5}, '{4'h2, 4'h1, 4'h3, 4'h9, 4'h5},
                                   '{4'hf, 4'he, 4'hc, 4'h6, 4'ha}};
   int              rxf [3] = '{1, 1, 2};

   modem_sync_signal_strength_and_channel_config modem_sync_signal_strength_and_channel_config_inst (
      .CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .CSN(CSN), .SI(SI), .SO(SO), .SO_OE(SO_OE),
      .RX_ENABLE(RX_ENABLE), .SYMBOL_STROBE(SYMBOL_STROBE), .RX_SYMBOL(RX_SYMBOL),
      .SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE(SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE), .CORR_LEVEL(CORR_LEVEL), .PREAMBLE_MATCH(PREAMBLE_MATCH),
      .CLEAR_CHANNEL_HYSTERESIS(CLEAR_CHANNEL_HYSTERESIS), .TX_SYNC_START(TX_SYNC_START),
      .SFD_SEARCH_EN(SFD_SEARCH_EN), .FREQ_FILTER_HOLD(FREQ_FILTER_HOLD), .PHASE_INVERT(PHASE_INVERT),
      .TX_SOURCE(TX_SOURCE), .RX_DEST(RX_DEST), .CHANNEL_FREE_FLAG(CHANNEL_FREE_FLAG),
      .SIGNAL_STRENGTH_VALID(SIGNAL_STRENGTH_VALID), .TX_SYMBOL(TX_SYMBOL),
      .TX_SYNC_ACTIVE(TX_SYNC_ACTIVE), .RX_SYNC_FOUND(RX_SYNC_FOUND));

   // ==========================================================
   // Clock and helpers
   always #10 CLK = ~CLK;
   always @(posedge CLK) if (RX_SYNC_FOUND === 1'b1) found_seen <= found_seen + 1;

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("Checks made: %0d, mismatches: %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Data bit i is sampled at the end of the low phase before its own rise
   task automatic xfer(input logic r, input logic [5:0] a, input logic [15:0] d);
      logic [23:0] f;
      f = {1'b0, r, a, d};
      CSN <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         SI <= f[i];
         tick(8);
         if (i < 16) sdata[i] = SO;
         if (i == 15) oe_seen = SO_OE;
         SCLK <= 1'b1;
         tick(8);
         SCLK <= 1'b0;
      end
      tick(8);
      CSN <= 1'b1;
      tick(8);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [15:0] e);
      xfer(1'b1, a, 16'h0000);
      check(sdata, e);
      check({oe_seen, SO_OE}, 2'b10);
   endtask
   task automatic sym(input logic [3:0] s, input logic [7:0] p);
      RX_SYMBOL <= s;
      SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE <= p;
      SYMBOL_STROBE <= 1'b1;
      tick(1);
      SYMBOL_STROBE <= 1'b0;
      tick(2);
   endtask

   // ==========================================================
   // Watchdog: the full sequence needs about 7500 cycles
   initial begin
      tick(60000);
      fail_count++;
      test_done();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {CLK, RESETN, SCLK, SI, RX_ENABLE, SYMBOL_STROBE, PREAMBLE_MATCH, TX_SYNC_START} = 8'h00;
      CSN = 1'b1;
      RX_SYMBOL = 4'h0;
      SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE = 8'h80;
      CORR_LEVEL = 5'h00;
      CLEAR_CHANNEL_HYSTERESIS = 3'h2;
      fail_count = 0;
      checks_done = 0;
      found_seen = 0;
      tick(2);
      RESETN <= 1'b1;
      tick(3);
      check(CHANNEL_FREE_FLAG, 1'b1);
      rchk(`REG_MODEM_CONTROL_ONE, 16'h0500);
      rchk(`REG_SIGNAL_STRENGTH, 16'he080);
      rchk(`REG_FRAME_SYNC_PATTERN, 16'ha70f);
      xfer(1'b0, `REG_MODEM_CONTROL_ONE, 16'h07ff);
      rchk(`REG_MODEM_CONTROL_ONE, 16'h07ff);
      check({PHASE_INVERT, TX_SOURCE, RX_DEST}, 5'h1f);
      for (int c = 0; c < 3; c++) begin
         xfer(1'b0, `REG_MODEM_CONTROL_ONE, {11'h000, c[0], c[1:0], c[1:0]});
         check(TX_SOURCE, c[1:0]);
         check(RX_DEST, c[1:0]);
         check(PHASE_INVERT, c[0]);
      end
      // Threshold 10 with the filter locking after preamble
      xfer(1'b0, `REG_MODEM_CONTROL_ONE, 16'h0280);
      RX_ENABLE <= 1'b1;
      CORR_LEVEL <= 5'h09;
      tick(3);
      check(SFD_SEARCH_EN, 1'b0);
      CORR_LEVEL <= 5'h0a;
      tick(3);
      check(SFD_SEARCH_EN, 1'b1);
      check(FREQ_FILTER_HOLD, 1'b0);
      PREAMBLE_MATCH <= 1'b1;
      tick(1);
      PREAMBLE_MATCH <= 1'b0;
      tick(3);
      check(FREQ_FILTER_HOLD, 1'b1);
      xfer(1'b0, `REG_MODEM_CONTROL_ONE, 16'h02a0);
      check(FREQ_FILTER_HOLD, 1'b0);
      repeat (7) sym(4'h0, 8'hd8);
      check(SIGNAL_STRENGTH_VALID, 1'b0);
      sym(4'h0, 8'hd8);
      check(SIGNAL_STRENGTH_VALID, 1'b1);
      rchk(`REG_SIGNAL_STRENGTH, 16'he0d8);
      check(CHANNEL_FREE_FLAG, 1'b1);
      repeat (8) sym(4'h0, 8'hec);
      check(CHANNEL_FREE_FLAG, 1'b0);
      repeat (8) sym(4'h0, 8'hdf);
      check(CHANNEL_FREE_FLAG, 1'b0);
      repeat (8) sym(4'h0, 8'hdd);
      check(CHANNEL_FREE_FLAG, 1'b1);
      xfer(1'b0, `REG_SIGNAL_STRENGTH, 16'h1055);
      rchk(`REG_SIGNAL_STRENGTH, 16'h10dd);
      RX_ENABLE <= 1'b0;
      tick(3);
      check(SIGNAL_STRENGTH_VALID, 1'b0);
      rchk(`REG_SIGNAL_STRENGTH, 16'h1080);
      // Transmit: nibbles f,2,f,1 go out low first, f as zero
      xfer(1'b0, `REG_FRAME_SYNC_PATTERN, 16'h1f2f);
      TX_SYNC_START <= 1'b1;
      tick(1);
      TX_SYNC_START <= 1'b0;
      tick(2);
      for (int n = 0; n < 4; n++) begin
         check(TX_SYNC_ACTIVE, 1'b1);
         check(TX_SYMBOL, txe[n]);
         sym(4'h0, 8'h80);
      end
      check({TX_SYNC_ACTIVE, TX_SYMBOL}, 5'h00);
      // Receive with threshold 0 so search follows the receiver enable
      xfer(1'b0, `REG_MODEM_CONTROL_ONE, 16'h0000);
      xfer(1'b0, `REG_FRAME_SYNC_PATTERN, 16'h5f31);
      for (int t = 0; t < 3; t++) begin
         if (t == 2) xfer(1'b0, `REG_MODEM_CONTROL_ONE, 16'h0010);
         RX_ENABLE <= 1'b1;
         tick(3);
         for (int k = 0; k < 5; k++) sym(rxs[t][k], 8'h80);
         tick(3);
         RX_ENABLE <= 1'b0;
         tick(3);
         check(found_seen[15:0], rxf[t][15:0]);
      end
      test_done();
   end
endmodule
`default_nettype wire

//--- src/modem_sync_signal_strength_and_channel_config.v
// Purpose: Modem control, signal-strength / clear-channel and sync-pattern registers with their datapath
// Assumes: Serial port frame is address byte (bit7 0, bit6 read, bits5:0 address) then 16 data bits MSB first
// Notes:   Serial pins cross into CLK through three flops and a filter flop; SCLK must be well below CLK/8
`timescale 1ns/100ps
`include "modem_sync_signal_strength_and_channel_defines.vh"
`default_nettype none

module modem_sync_signal_strength_and_channel_config (
   // System
   input  wire        CLK,
   input  wire        RESETN,
   // Serial configuration port
   input  wire        SCLK,
   input  wire        CSN,
   input  wire        SI,
   output wire        SO,
   output wire        SO_OE,
   // Demodulator and receive-path status, plus transmit sync start
   input  wire        RX_ENABLE,
   input  wire        SYMBOL_STROBE,
   input  wire [3:0]  RX_SYMBOL,
   input  wire [7:0]  SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE,
   input  wire [4:0]  CORR_LEVEL,
   input  wire        PREAMBLE_MATCH,
   input  wire [2:0]  CLEAR_CHANNEL_HYSTERESIS,
   input  wire        TX_SYNC_START,
   // Modem controls
   output wire        SFD_SEARCH_EN,
   output wire        FREQ_FILTER_HOLD,
   output wire        PHASE_INVERT,
   output wire [1:0]  TX_SOURCE,
   output wire [1:0]  RX_DEST,
   output wire        CHANNEL_FREE_FLAG,
   output wire        SIGNAL_STRENGTH_VALID,
   // Sync pattern
   output wire [3:0]  TX_SYMBOL,
   output wire        TX_SYNC_ACTIVE,
   output wire        RX_SYNC_FOUND
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_SEND = 2'b10;

   // ==========================================================
   // Pin synchronisers: {SCLK, CSN, SI}
   // Chains reset to the idle level of their pin so no edge is seen after reset
   localparam [2:0] PIN_IDLE = `PIN_IDLE_LEVELS;
   wire [2:0] pin_in;
   wire [2:0] pin_f;
   genvar g;
   assign pin_in = {SCLK, CSN, SI};
   generate
      for (g = 0; g < 3; g = g + 1) begin : pin_sync
         reg [2:0] s_q;
         reg       f_q;
         always @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               s_q <= {3{PIN_IDLE[g]}};
               f_q <= PIN_IDLE[g];
            end else begin
               s_q <= {s_q[1:0], pin_in[g]};
               // Noise is rejected: a level counts only once two stages agree
               if (s_q[1] == s_q[2]) begin
                  f_q <= s_q[2];
               end
            end
         end
         assign pin_f[g] = f_q;
      end
   endgenerate

   wire sclk_f = pin_f[2];
   wire csn_f  = pin_f[1];
   wire si_f   = pin_f[0];

   // ==========================================================
   // Registers and serial access
   reg  [`CTRL_USED_MSB:0] ctrl_q;
   reg  [7:0]              thr_q;
   reg  [15:0]             sync_q;
   reg                     sclk_prev_q;
   reg  [4:0]              bit_cnt_q;
   reg  [15:0]             sh_q;
   reg  [15:0]             rd_sh_q;
   reg  [7:0]              addr_q;
   reg                     so_q;
   reg                     so_oe_q;
   reg  [7:0]              signal_strength_value_q;
   reg  [15:0]             rd_data;
   wire [7:0]              addr_now = {sh_q[6:0], si_f};
   wire [15:0]             wr_data  = {sh_q[14:0], si_f};
   wire                    sclk_rise = sclk_f & ~sclk_prev_q;
   wire                    sclk_fall = ~sclk_f & sclk_prev_q;

   always @* begin
      case (addr_now[5:0])
         `REG_MODEM_CONTROL_ONE:  rd_data = {5'h00, ctrl_q};
         `REG_SIGNAL_STRENGTH:    rd_data = {thr_q, signal_strength_value_q};
         `REG_FRAME_SYNC_PATTERN: rd_data = sync_q;
         default:                 rd_data = 16'h0000;
      endcase
   end

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_q      <= {`CORRELATOR_THRESHOLD_RESET, 6'h00};
         thr_q       <= `CLEAR_CHANNEL_THRESHOLD_RESET;
         sync_q      <= `SYNC_RESET;
         sclk_prev_q <= 1'b0;
         bit_cnt_q   <= 5'h00;
         sh_q        <= 16'h0000;
         rd_sh_q     <= 16'h0000;
         addr_q      <= 8'h00;
         so_q        <= 1'b0;
         so_oe_q     <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_f;
         so_oe_q     <= ~csn_f;
         if (csn_f) begin
            bit_cnt_q <= 5'h00;
            so_q      <= 1'b0;
         end else if (sclk_rise && bit_cnt_q != `FRAME_BITS) begin
            sh_q      <= wr_data;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `ADDR_LAST_BIT) begin
               addr_q  <= addr_now;
               so_q    <= addr_now[6] & rd_data[15];
               rd_sh_q <= {rd_data[14:0], 1'b0};
            end
            // Commit on the last data bit; reads and bit7=1 frames never write
            if (bit_cnt_q == `WORD_LAST_BIT && !addr_q[7] && !addr_q[6]) begin
               case (addr_q[5:0])
                  // Reserved bits 15:11 are not stored and read back as zero
                  `REG_MODEM_CONTROL_ONE:  ctrl_q <= wr_data[`CTRL_USED_MSB:0];
                  `REG_SIGNAL_STRENGTH:    thr_q  <= wr_data[15:8];
                  `REG_FRAME_SYNC_PATTERN: sync_q <= wr_data;
                  default:                 ctrl_q <= ctrl_q;
               endcase
            end
         end else if (sclk_fall && bit_cnt_q > `DATA_FIRST_OUT) begin
            so_q    <= addr_q[6] & rd_sh_q[15];
            rd_sh_q <= {rd_sh_q[14:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // Modem control outputs
   reg sfd_search_q;
   reg preamble_seen_q;
   reg filter_hold_q;
   reg phase_q;
   reg [1:0] tx_src_q;
   reg [1:0] rx_dst_q;

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sfd_search_q    <= 1'b0;
         preamble_seen_q <= 1'b0;
         filter_hold_q   <= 1'b0;
         phase_q         <= 1'b0;
         tx_src_q        <= 2'h0;
         rx_dst_q        <= 2'h0;
      end else begin
         sfd_search_q    <= RX_ENABLE && (CORR_LEVEL >= ctrl_q[`CORRELATOR_THRESHOLD_MSB:`CORRELATOR_THRESHOLD_LSB]);
         preamble_seen_q <= RX_ENABLE & (preamble_seen_q | PREAMBLE_MATCH);
         // Freeze follows the match in the same cycle it is seen
         filter_hold_q   <= ~ctrl_q[`FILTER_MODE_BIT] & RX_ENABLE & (preamble_seen_q | PREAMBLE_MATCH);
         phase_q         <= ctrl_q[`PHASE_BIT];
         tx_src_q        <= ctrl_q[`TX_MODE_MSB:`TX_MODE_LSB];
         rx_dst_q        <= ctrl_q[`RX_MODE_MSB:`RX_MODE_LSB];
      end
   end

   // ==========================================================
   // Signal strength average and channel-free indication
   reg  [63:0] win_q;
   reg  [10:0] sum_q;
   reg  [3:0]  cnt_q;
   reg         valid_q;
   reg         free_q;
   wire [10:0] sum_d = sum_q + {{3{SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE[7]}}, SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE} - {{3{win_q[63]}}, win_q[63:56]};
   wire signed [8:0] thr_s  = {thr_q[7], thr_q};
   wire signed [8:0] low_s  = thr_s - $signed({6'h00, CLEAR_CHANNEL_HYSTERESIS});
   wire signed [8:0] signal_strength_and_channel_s = {signal_strength_value_q[7], signal_strength_value_q};

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         win_q      <= 64'h0;
         sum_q      <= 11'h000;
         cnt_q      <= 4'h0;
         valid_q    <= 1'b0;
         signal_strength_value_q <= `SIGNAL_STRENGTH_AND_CHANNEL_INVALID;
         free_q     <= 1'b0;
      end else begin
         if (!RX_ENABLE) begin
            win_q      <= 64'h0;
            sum_q      <= 11'h000;
            cnt_q      <= 4'h0;
            valid_q    <= 1'b0;
            signal_strength_value_q <= `SIGNAL_STRENGTH_AND_CHANNEL_INVALID;
         end else if (SYMBOL_STROBE) begin
            win_q <= {win_q[55:0], SIGNAL_STRENGTH_AND_CHANNEL_SAMPLE};
            sum_q <= sum_d;
            if (cnt_q != `AVG_SYMBOLS) begin
               cnt_q <= cnt_q + 4'h1;
            end
            if (cnt_q >= `AVG_SYMBOLS - 4'h1) begin
               valid_q    <= 1'b1;
               signal_strength_value_q <= sum_d[10:3];
            end
         end
         if (signal_strength_and_channel_s >= thr_s) begin
            free_q <= 1'b0;
         end else if (signal_strength_and_channel_s < low_s) begin
            free_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Sync pattern: transmit sequencer
   reg [1:0] tx_st_q;
   reg [1:0] tx_idx_q;
   reg [3:0] tx_sym_q;

   function [3:0] tx_nibble;
      input [15:0] pat;
      input [1:0]  idx;
      reg   [3:0]  n;
      begin
         n = pat[idx*4 +: 4];
         tx_nibble = (n == 4'hf) ? 4'h0 : n;
      end
   endfunction

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_st_q  <= ST_IDLE;
         tx_idx_q <= 2'h0;
         tx_sym_q <= 4'h0;
      end else begin
         case (tx_st_q)
            ST_IDLE: begin
               if (TX_SYNC_START) begin
                  tx_st_q  <= ST_SEND;
                  tx_idx_q <= 2'h0;
                  tx_sym_q <= tx_nibble(sync_q, 2'h0);
               end
            end
            ST_SEND: begin
               if (SYMBOL_STROBE) begin
                  if (tx_idx_q == 2'h3) begin
                     tx_st_q  <= ST_IDLE;
                     tx_sym_q <= 4'h0;
                  end else begin
                     tx_idx_q <= tx_idx_q + 2'h1;
                     tx_sym_q <= tx_nibble(sync_q, tx_idx_q + 2'h1);
                  end
               end
            end
            default: tx_st_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Sync pattern: receive matcher
   reg  [19:0] hist_q;
   reg  [2:0]  hist_cnt_q;
   reg         check_q;
   reg         found_q;
   reg  [2:0]  first_k;
   wire [3:0]  nib_ok;
   wire [3:0]  zero_nib = hist_q[(3'h4 - first_k)*4 +: 4];
   integer     i;

   generate
      for (g = 0; g < 4; g = g + 1) begin : nib_cmp
         // Nibble g arrived (3-g) symbols before the newest one
         assign nib_ok[g] = (sync_q[g*4 +: 4] == 4'hf) ||
                            (hist_q[(3-g)*4 +: 4] == sync_q[g*4 +: 4]);
      end
   endgenerate

   always @* begin
      first_k = 3'h4;
      for (i = 3; i >= 0; i = i - 1) begin
         if (sync_q[i*4 +: 4] != 4'hf) begin
            first_k = i[2:0];
         end
      end
   end

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         hist_q     <= 20'h0;
         hist_cnt_q <= 3'h0;
         check_q    <= 1'b0;
         found_q    <= 1'b0;
      end else begin
         check_q <= 1'b0;
         found_q <= 1'b0;
         if (!sfd_search_q) begin
            hist_q     <= 20'h0;
            hist_cnt_q <= 3'h0;
         end else if (SYMBOL_STROBE) begin
            hist_q  <= {hist_q[15:0], phase_q ? ~RX_SYMBOL : RX_SYMBOL};
            check_q <= 1'b1;
            if (hist_cnt_q != 3'h5) begin
               hist_cnt_q <= hist_cnt_q + 3'h1;
            end
         end
         if (check_q && hist_cnt_q == 3'h5) begin
            found_q <= (&nib_ok) && (zero_nib == 4'h0);
         end
      end
   end

   // ==========================================================
   // Outputs
   assign SO                    = so_q;
   assign SO_OE                 = so_oe_q;
   assign SFD_SEARCH_EN         = sfd_search_q;
   assign FREQ_FILTER_HOLD      = filter_hold_q;
   assign PHASE_INVERT          = phase_q;
   assign TX_SOURCE             = tx_src_q;
   assign RX_DEST               = rx_dst_q;
   assign CHANNEL_FREE_FLAG     = free_q;
   assign SIGNAL_STRENGTH_VALID = valid_q;
   assign TX_SYMBOL             = tx_sym_q;
   assign TX_SYNC_ACTIVE        = tx_st_q[1];
   assign RX_SYNC_FOUND         = found_q;

endmodule

`default_nettype wire

//--- src/modem_sync_signal_strength_and_channel_defines.vh
// Purpose: Constants for the modem sync / signal-strength configuration block
// Assumes: Included by bare name from src/
// Notes:   Register offsets are 6-bit serial-port addresses
// Functional notes
// - Start-of-frame search only runs once correlation reaches the 5-bit threshold in bits 10:6, reset 20.
// - Filter-mode bit 5 at 0 freezes the frequency-offset filter after preamble match, at 1 it updates always.
// - Phase bit 4 at 0 gives standard modulation for transmit and receive, at 1 the phase is reversed.
// - Transmit-test bits 3:2 pick the source: buffer, serial pin, cyclic buffer, or pseudo-random checksum data.
// - Receive-test bits 1:0 pick the sink: buffer, output pins, cyclic buffer, with code 3 reserved.
// - The clear-channel threshold is a signed 8-bit dB value in bits 15:8 that resets to -32.
// - The channel-free indication is asserted when strength is below threshold and is driven on its own pin.
// - A read-only signed 8-bit dB strength estimate in bits 7:0 is averaged over 8 symbol periods.
// - The strength-valid bit is set only once the receiver has been on for at least 8 symbol periods.
// - After reset the estimate reads -128, which marks it as not valid.
// - The 16-bit sync pattern, reset 0xA70F, is handled one nibble at a time from the lowest nibble up.
// - When modulating, each sync nibble of 0xF is sent as a zero symbol.
// - When demodulating, sync nibbles of 0xF are not required and only the others must match.
// - In reception a zero symbol must directly precede the first symbol that the pattern requires.
// - Channel becomes free below threshold minus a 0 to 7 dB hysteresis and busy at or above threshold.
`ifndef MODEM_SYNC_SIGNAL_STRENGTH_AND_CHANNEL_DEFINES_VH
`define MODEM_SYNC_SIGNAL_STRENGTH_AND_CHANNEL_DEFINES_VH

// ==========================================================
// Register offsets
`define REG_MODEM_CONTROL_ONE   6'h12
`define REG_SIGNAL_STRENGTH     6'h13
`define REG_FRAME_SYNC_PATTERN  6'h14

// ==========================================================
// Field positions
`define CORRELATOR_THRESHOLD_MSB            10
`define CORRELATOR_THRESHOLD_LSB            6
`define FILTER_MODE_BIT         5
`define PHASE_BIT               4
`define TX_MODE_MSB             3
`define TX_MODE_LSB             2
`define RX_MODE_MSB             1
`define RX_MODE_LSB             0
`define CTRL_USED_MSB           10

// ==========================================================
// Reset values
`define CORRELATOR_THRESHOLD_RESET          5'h14
`define CLEAR_CHANNEL_THRESHOLD_RESET           8'he0
`define SIGNAL_STRENGTH_AND_CHANNEL_INVALID            8'h80
`define SYNC_RESET              16'ha70f
`define PIN_IDLE_LEVELS         3'h2

// ==========================================================
// Timing and serial framing
`define AVG_SYMBOLS             4'h8
`define ADDR_LAST_BIT           5'h07
`define DATA_FIRST_OUT          5'h08
`define WORD_LAST_BIT           5'h17
`define FRAME_BITS              5'h18

`endif
